/* File: sram_host_ctrl.sv */
// host side controller driving a 1024 x 4 asynchronous static ram with array clear
// assumes the ram pins are wired straight to the o_ pins and i_read_data_out
// Functional notes
// - write needs select and write enable low
// - write ends at first rising strobe, data held
// - clear stays high during every write
// - write enable and clear high while reading
// - clear keeps address, select low, write high
module sram_host_ctrl (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   // user command port
   input  wire logic       i_req,
   input  wire logic [1:0] i_cmd,
   input  wire logic [9:0] i_addr,
   input  wire logic [3:0] i_wdata,
   output logic            o_ready,
   output logic            o_done,
   output logic [3:0]      o_rdata,
   // ram pins
   output logic [9:0]      o_word_address,
   output logic [3:0]      o_write_data_in,
   output logic            o_cs_n,
   output logic            o_we_n,
   output logic            o_oe_n,
   output logic            o_clr_n,
   input  wire logic [3:0] i_read_data_out
);

   // controller phases
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WSETUP,
      ST_WSTROBE,
      ST_WREC,
      ST_READ,
      ST_CSETUP,
      ST_CPULSE,
      ST_CHOLD
   } state_type;

   state_type                          state_reg;    // current phase
   state_type                          state_next;   // phase after this edge
   logic [sram_host_pkg::CNT_W-1:0]    cnt_reg;      // cycles left in phase
   logic [sram_host_pkg::CNT_W-1:0]    cnt_next;     // counter after this edge
   logic [3:0]                         rd_sync;      // read data after sync
   logic                               accept;       // request taken this edge

   // phase length as a counter load value
   function automatic logic [sram_host_pkg::CNT_W-1:0] load(input int cyc);
      return sram_host_pkg::CNT_W'(cyc - 1);
   endfunction

   // read data pins cross into the clock domain here
   sram_pin_sync #(
      .WIDTH   (4)
   ) u_rd_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   (i_read_data_out),
      .o_sync    (rd_sync)
   );

   // only the three known codes are taken; an unknown code leaves pins and state alone
   assign accept = i_req && (state_reg == ST_IDLE) &&
                   ((i_cmd == sram_host_pkg::CMD_READ) ||
                    (i_cmd == sram_host_pkg::CMD_WRITE) ||
                    (i_cmd == sram_host_pkg::CMD_CLEAR));

   // phase sequencing
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'h1 : cnt_reg;
      case (state_reg)
         ST_IDLE:
         begin
            // pick the access kind; unknown codes are ignored
            if (i_req && i_cmd == sram_host_pkg::CMD_WRITE)
            begin
               state_next = ST_WSETUP;
               cnt_next   = load(sram_host_pkg::SETUP_CYC);
            end
            else if (i_req && i_cmd == sram_host_pkg::CMD_READ)
            begin
               state_next = ST_READ;
               cnt_next   = load(sram_host_pkg::READ_CYC);
            end
            else if (i_req && i_cmd == sram_host_pkg::CMD_CLEAR)
            begin
               state_next = ST_CSETUP;
               cnt_next   = load(sram_host_pkg::CSETUP_CYC);
            end
         end
         ST_WSETUP:
         begin
            // address and data settle before the strobe
            if (cnt_reg == '0)
            begin
               state_next = ST_WSTROBE;
               cnt_next   = load(sram_host_pkg::STROBE_CYC);
            end
         end
         ST_WSTROBE:
         begin
            // write enable low for the pulse width
            if (cnt_reg == '0)
            begin
               state_next = ST_WREC;
               cnt_next   = load(sram_host_pkg::WREC_CYC);
            end
         end
         ST_WREC:
         begin
            // data and address held after the rising edge
            if (cnt_reg == '0)
               state_next = ST_IDLE;
         end
         ST_READ:
         begin
            // access time plus synchroniser latency
            if (cnt_reg == '0)
               state_next = ST_IDLE;
         end
         ST_CSETUP:
         begin
            if (cnt_reg == '0)
            begin
               state_next = ST_CPULSE;
               cnt_next   = load(sram_host_pkg::CPULSE_CYC);
            end
         end
         ST_CPULSE:
         begin
            // clear held low for the pulse width
            if (cnt_reg == '0)
            begin
               state_next = ST_CHOLD;
               cnt_next   = load(sram_host_pkg::CHOLD_CYC);
            end
         end
         ST_CHOLD:
         begin
            // address and select held after clear rises
            if (cnt_reg == '0)
               state_next = ST_IDLE;
         end
         default:
         begin
            state_next = ST_IDLE;
            cnt_next   = '0;
         end
      endcase
   end

   // phase register
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg <= ST_IDLE;
         cnt_reg   <= '0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // address and write data latched on accept, stable for the whole access
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_word_address  <= sram_host_pkg::ADDR_RESET;
         o_write_data_in <= sram_host_pkg::DATA_RESET;
      end
      else if (accept)
      begin
         o_word_address  <= i_addr;
         o_write_data_in <= i_wdata;
      end
   end

   // strobes registered from the next phase so they line up with it
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_cs_n  <= sram_host_pkg::STROBE_IDLE;
         o_we_n  <= sram_host_pkg::STROBE_IDLE;
         o_oe_n  <= sram_host_pkg::STROBE_IDLE;
         o_clr_n <= sram_host_pkg::STROBE_IDLE;
      end
      else
      begin
         // select low through every access phase
         o_cs_n  <= (state_next == ST_IDLE);
         // write enable low only inside the strobe phase
         o_we_n  <= (state_next != ST_WSTROBE);
         // outputs enabled only for a read
         o_oe_n  <= (state_next != ST_READ);
         // clear low only inside the clear pulse
         o_clr_n <= (state_next != ST_CPULSE);
      end
   end

   // user side handshake and read data capture
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ready <= 1'h1;
         o_done  <= 1'h0;
         o_rdata <= sram_host_pkg::DATA_RESET;
      end
      else
      begin
         o_ready <= (state_next == ST_IDLE);
         o_done  <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
         // sample at the end of the read phase
         if (state_reg == ST_READ && cnt_reg == '0)
            o_rdata <= rd_sync;
      end
   end

   // checks on the pin sequence

   // write strobe: one low cycle with select held low
   sequence write_strobe_s;
      !o_we_n && !o_cs_n && o_clr_n;
   endsequence

   // write end: strobe up, select and data still held
   sequence write_end_s;
      o_we_n && !o_cs_n && $stable(o_write_data_in) && $stable(o_word_address);
   endsequence

   we_needs_cs_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !o_we_n |-> !o_cs_n)
      else $error("write enable low without chip select");

   write_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $fell(o_we_n) |-> write_strobe_s ##1 write_end_s)
      else $error("write pulse wrong length or select dropped");

   write_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_we_n) && !o_cs_n |-> $stable(o_write_data_in) ##1 o_cs_n)
      else $error("write data not held across strobe rise");

   clear_in_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !o_we_n |-> o_clr_n)
      else $error("clear active during write");

   read_levels_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !o_oe_n |-> o_we_n && o_clr_n && !o_cs_n)
      else $error("read without write enable and clear high");

   read_length_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $fell(o_oe_n) |-> !o_oe_n [*3] ##1 o_oe_n)
      else $error("read phase not three cycles");

   clear_levels_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !o_clr_n |-> !o_cs_n && o_we_n && o_oe_n && $stable(o_word_address))
      else $error("clear without select low, write high, address stable");

   clear_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_clr_n) |-> !o_cs_n ##1 o_cs_n && o_done)
      else $error("select not held after clear end");

   done_bound_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept |-> ##[3:4] o_done)
      else $error("access did not finish in time");

endmodule

/* File: sram_host_pkg.sv */
// constants shared by the static ram host controller and its testbench
// assumes a single 10 MHz reference clock and an active high asynchronous reset
package sram_host_pkg;

   // array shape of the attached memory
   localparam int ADDR_W        = 10;      // word address width
   localparam int DATA_W        = 4;       // word width
   localparam int WORD_COUNT    = 1024;    // words in the array

   // clock rate of the controller
   localparam int CLK_PERIOD_NS = 100;     // 10 MHz reference clock

   // least times of the slowest speed grade, in ns
   localparam int T_AS_NS       = 5;       // address valid to write start
   localparam int T_WP_NS       = 30;      // write pulse width
   localparam int T_DW_NS       = 30;      // data valid to write end
   localparam int T_WR_NS       = 5;       // address hold after write end
   localparam int T_DH_NS       = 5;       // data hold after write end
   localparam int T_AA_NS       = 45;      // address access time
   localparam int T_RSA_NS      = 0;       // address valid to clear start
   localparam int T_RP_NS       = 40;      // clear pulse width
   localparam int T_RHA_NS      = 50;      // address hold after clear end

   // synchroniser depth on the read data pins
   localparam int SYNC_STAGES   = 2;

   // least time to whole cycles, never below one
   function automatic int min_cycles(input int t_ns);
      int c;
      c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // larger of two figures
   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // phase lengths in cycles
   localparam int SETUP_CYC     = min_cycles(T_AS_NS);
   localparam int STROBE_CYC    = min_cycles(max2(T_WP_NS, T_DW_NS));
   localparam int WREC_CYC      = min_cycles(max2(T_WR_NS, T_DH_NS));
   localparam int READ_CYC      = min_cycles(T_AA_NS) + SYNC_STAGES;
   localparam int CSETUP_CYC    = min_cycles(T_RSA_NS);
   localparam int CPULSE_CYC    = min_cycles(T_RP_NS);
   localparam int CHOLD_CYC     = min_cycles(T_RHA_NS);

   // phase counter width
   localparam int CNT_W         = 4;

   // command codes on the user port
   localparam logic [1:0] CMD_READ  = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_CLEAR = 2'h2;

   // pin levels after reset
   localparam logic       STROBE_IDLE = 1'h1;           // all strobes inactive high
   localparam logic [9:0] ADDR_RESET  = 10'h000;
   localparam logic [3:0] DATA_RESET  = 4'h0;

endpackage

/* File: sram_model.sv */
// behavioural 1024 x 4 static ram with array clear, seen from its pins
// assumes the pins come straight from the host controller, no clock of its own
module sram_model (
   // ram pins
   input  wire logic [9:0] i_word_address,
   input  wire logic [3:0] i_write_data_in,
   input  wire logic       i_cs_n,
   input  wire logic       i_we_n,
   input  wire logic       i_oe_n,
   input  wire logic       i_clr_n,
   output logic      [3:0] o_read_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] mem [1024];  // storage words
   logic [3:0] last_q = 4'h0;  // last driven word
   logic       upd = 1'b0;  // toggles on every array change
   logic       rd;  // outputs driven
   assign rd = !i_cs_n && i_we_n && !i_oe_n && i_clr_n;
   // write ends at the first rising strobe
   always @(posedge i_we_n or posedge i_cs_n)
   begin
      if (i_cs_n !== i_we_n && i_clr_n === 1'b1)
      begin
         mem[i_word_address] = i_write_data_in;
         upd = ~upd;
      end
   end
   // clear zeroes every word whatever the address
   always @(i_clr_n or i_cs_n)
   begin
      if (i_clr_n === 1'b0 && i_cs_n === 1'b0)
      begin
         for (int k = 0; k < 1024; k++) mem[k] = 4'h0;
         upd = ~upd;
      end
   end
   // released outputs show the inverse of the last word, never a stale copy
   always @(rd or i_word_address or upd)
   begin
      if (rd)
      begin
         last_q = mem[i_word_address];
         o_read_data_out = last_q;
      end
      else o_read_data_out = ~last_q;
   end
endmodule

/* File: sram_pin_sync.sv */
// two flip-flop synchroniser for a group of pins
// assumes the pins are quasi static while sampled; bits are not aligned to each other
module sram_pin_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   // asynchronous pins and their synchronised copy
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1_reg;   // first stage, read only by the second

   // two stage capture
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         stage1_reg <= '0;
         o_sync     <= '0;
      end
      else
      begin
         stage1_reg <= i_async;
         o_sync     <= stage1_reg;
      end
   end

endmodule

/* File: testbench.sv */
// self-checking bench for the static ram host controller
// assumes the ram model on the pins and a reference array in the bench
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // design ports
   logic       i_ref_clk, i_rst, i_req;
   logic [1:0] i_cmd;
   logic [9:0] i_addr, o_word_address;
   logic [3:0] i_wdata, o_rdata, o_write_data_in, ram_q;
   logic       o_ready, o_done, o_cs_n, o_we_n, o_oe_n, o_clr_n;
   // bench state
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   int seed = 32'h8fb6;
   int ref_mem [1024];  // reference array
   int lat;
   logic [9:0] aq [$];  // addresses written
   sram_host_ctrl i_sram_host_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(i_req),
      .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done),
      .o_rdata(o_rdata), .o_word_address(o_word_address), .o_write_data_in(o_write_data_in),
      .o_cs_n(o_cs_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_clr_n(o_clr_n),
      .i_read_data_out(ram_q));
   sram_model i_sram_model (.i_word_address(o_word_address), .i_write_data_in(o_write_data_in),
      .i_cs_n(o_cs_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_clr_n(o_clr_n),
      .o_read_data_out(ram_q));
   // clock
   initial
   begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   // hang guard
   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   // verdict
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one comparison
   task automatic check(string what, logic [9:0] exp, logic [9:0] seen);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // reset and idle pin levels
   task automatic do_reset();
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      #1;
      check("strobes", 10'h00F, {o_cs_n, o_we_n, o_oe_n, o_clr_n});
      check("ready", 10'h001, o_ready);
   endtask
   // one access and its expected outcome
   task automatic op(logic [1:0] c, logic [9:0] a, logic [3:0] d);
      @(posedge i_ref_clk);
      i_req <= 1'b1;
      i_cmd <= c;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_req <= 1'b0;
      #1;
      if (c != 2'h3) check("address pins", a, o_word_address);
      lat = 0;
      do
      begin
         @(posedge i_ref_clk);
         lat++;
         #1;
      end
      while (o_done !== 1'b1 && lat < 8);
      if (c == 2'h3)
      begin
         check("refused", 10'h008, lat[9:0]);
         check("ready after refused", 10'h001, o_ready);
         return;
      end
      check("latency", 10'h003, lat[9:0]);
      if (c == sram_host_pkg::CMD_WRITE) ref_mem[a] = d;
      if (c == sram_host_pkg::CMD_CLEAR) foreach (ref_mem[k]) ref_mem[k] = 0;
      if (c == sram_host_pkg::CMD_READ) check("rdata", ref_mem[a], o_rdata);
   endtask
   // main sequence
   initial
   begin
      i_rst = 1'b1;
      i_req = 1'b0;
      i_cmd = 2'h0;
      i_addr = 10'h000;
      i_wdata = 4'h0;
      do_reset();
      op(sram_host_pkg::CMD_CLEAR, 10'h155, 4'h0);
      $display("test reset and clear done");
      foreach (aq[k]) aq.delete();
      aq = '{10'h000, 10'h3FF, 10'h200, 10'h001};
      foreach (aq[k]) op(sram_host_pkg::CMD_WRITE, aq[k], 4'hF - k[3:0]);
      foreach (aq[k]) op(sram_host_pkg::CMD_READ, aq[k], 4'h0);
      $display("test boundary addresses done");
      repeat (40)
      begin
         aq.push_back(10'($random(seed)));
         op(sram_host_pkg::CMD_WRITE, aq[$], 4'($random(seed)));
      end
      foreach (aq[k]) op(sram_host_pkg::CMD_READ, aq[k], 4'h0);
      $display("test random writes done");
      op(2'h3, aq[0], 4'h5);
      op(sram_host_pkg::CMD_READ, aq[0], 4'h0);
      $display("test refused command done");
      do_reset();
      foreach (aq[k]) op(sram_host_pkg::CMD_READ, aq[k], 4'h0);
      $display("test second reset done");
      op(sram_host_pkg::CMD_CLEAR, aq[3], 4'h0);
      foreach (aq[k]) op(sram_host_pkg::CMD_READ, aq[k], 4'h0);
      op(sram_host_pkg::CMD_WRITE, 10'h3FF, 4'h9);
      op(sram_host_pkg::CMD_READ, 10'h3FF, 4'h0);
      op(sram_host_pkg::CMD_READ, 10'h3FE, 4'h0);
      $display("test clear then write done");
      summarize();
   end
endmodule
